// file: rtl/dif_defines.svh
// Constants for the drive input function decoder
`ifndef DIF_DEFINES_SVH
`define DIF_DEFINES_SVH
`define DIF_FN_SPEED_L     6'h00
`define DIF_FN_SPEED_M     6'h01
`define DIF_FN_SPEED_H     6'h02
`define DIF_FN_RAMP_L      6'h03
`define DIF_FN_RAMP_M      6'h04
`define DIF_FN_RAMP_H      6'h05
`define DIF_FN_BRAKE       6'h06
`define DIF_FN_SECOND      6'h07
`define DIF_FN_EXCHANGE    6'h08
`define DIF_FN_UP          6'h0a
`define DIF_FN_DOWN        6'h0b
`define DIF_FN_THREE_WIRE  6'h0c
`define DIF_FN_TRIP_A      6'h0d
`define DIF_FN_TRIP_B      6'h0e
`define DIF_FN_ICLEAR      6'h0f
`define DIF_FN_OPEN_LOOP   6'h10
`define DIF_FN_MAIN_DRIVE  6'h11
`define DIF_FN_ANA_HOLD    6'h12
`define DIF_FN_FREEZE      6'h13
`define DIF_FN_PGAIN2      6'h14
`define DIF_FN_PROG_L      6'h15
`define DIF_FN_PROG_M      6'h16
`define DIF_FN_PROG_H      6'h17
`define DIF_FN_MANUAL      6'h18
`define DIF_FN_GO_STEP     6'h19
`define DIF_FN_HOLD_STEP   6'h1a
`define DIF_FN_RESET       6'h22
`define DIF_FN_HALT        6'h23
`define DIF_FN_JOG         6'h24
`define DIF_FN_FWD         6'h25
`define DIF_FN_REV         6'h26
`define DIF_FN_ANA_CHANGE  6'h27
`define DIF_FN_PRE_EXCITE  6'h28
`define DIF_FN_MAX         6'h2a
`define DIF_UNIT_NS        500000
`define DIF_CLK_NS         20
`define DIF_UNIT_CYC       ((`DIF_UNIT_NS) / (`DIF_CLK_NS))
`define DIF_GAP_NS         50000000
`define DIF_GAP_CYC        ((`DIF_GAP_NS) / (`DIF_CLK_NS))
`define DIF_STEPS          3'h7
`define DIF_STEP_FIRST     3'h0
`define DIF_REF_PRESET     2'h0
`define DIF_REF_MODE       2'h1
`define DIF_REF_JOG        2'h2
`define DIF_REF_HOLD       2'h3
`endif

// file: rtl/dif_pkg.sv
// Types shared by the drive input function decoder
package dif_pkg;
   typedef enum logic [2:0] {
      DIF_LINE_INV  = 3'b000,
      DIF_GAP_COMM  = 3'b001,
      DIF_LINE_COMM = 3'b010,
      DIF_GAP_INV   = 3'b011
   } dif_line_type;

   typedef enum logic [1:0] {
      DIF_SEQ_IDLE = 2'b00,
      DIF_SEQ_RUN  = 2'b01,
      DIF_SEQ_HOLD = 2'b10
   } dif_seq_type;

   // Decoded function levels after filtering
   typedef struct packed {
      logic [2:0] speed;
      logic [2:0] ramp;
      logic [2:0] prog;
      logic       brake;
      logic       second;
      logic       exchange;
      logic       up;
      logic       down;
      logic       three_wire;
      logic       trip_a;
      logic       trip_b;
      logic       trip_b_used;
      logic       iclear;
      logic       open_loop;
      logic       main_drive;
      logic       ana_hold;
      logic       freeze;
      logic       pgain2;
      logic       manual;
      logic       go_step;
      logic       hold_step;
      logic       reset;
      logic       halt;
      logic       jog;
      logic       fwd;
      logic       rev;
      logic       ana_change;
      logic       pre_excite;
   } dif_func_type;
endpackage : dif_pkg

// file: rtl/dif_filter.sv
// Two-stage synchroniser and debounce filter for the input terminals
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_filter
   import dif_pkg::*;
#(
   parameter int W = 8,
   parameter int UNIT_CYC = `DIF_UNIT_CYC
)
(
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] pin_in,
   input  wire logic [7:0]   filter_units,
   output logic [W-1:0]      clean
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] clean;
      logic [31:0]  tick;
      logic [7:0]   units;
   } dif_flt_state_type;

   dif_flt_state_type st_ff;
   dif_flt_state_type nxt_st;

   // Filter waits filter_units * 0.5 ms of a stable level
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.meta = pin_in;
      nxt_st.sync = st_ff.meta;
      if (st_ff.sync == st_ff.clean)
      begin
         nxt_st.tick  = 32'h0;
         nxt_st.units = 8'h0;
      end
      else if (st_ff.units >= filter_units)
      begin
         // Whole word taken at once, so select bits change together
         nxt_st.clean = st_ff.sync;
         nxt_st.tick  = 32'h0;
         nxt_st.units = 8'h0;
      end
      else if (st_ff.tick >= 32'(UNIT_CYC - 1))
      begin
         nxt_st.tick  = 32'h0;
         nxt_st.units = st_ff.units + 8'h1;
      end
      else
      begin
         nxt_st.tick = st_ff.tick + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign clean = st_ff.clean;
endmodule : dif_filter
`default_nettype wire

// file: rtl/dif_decoder.sv
// Multi-function input terminal decoder for a motor drive
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_decoder
   import dif_pkg::*;
#(
   parameter int NIN = 8,
   parameter int UNIT_CYC = `DIF_UNIT_CYC,
   parameter int GAP_CYC = `DIF_GAP_CYC
)
(
   input  wire logic           clk,
   input  wire logic           arst_n,
   input  wire logic [NIN-1:0] term_pin,
   input  wire logic [NIN*6-1:0] term_func,
   input  wire logic [7:0]     filter_units,
   input  wire logic           motor_stopped,
   input  wire logic           auto_mode,
   input  wire logic           auto_stepped,
   input  wire logic           ref_is_analog,
   input  wire logic           step_done,
   output logic [2:0]          preset_index,
   output logic [1:0]          ref_source,
   output logic [2:0]          ramp_index,
   output logic                ramp_up,
   output logic                ramp_down,
   output logic                ramp_hold,
   output logic                brake_on,
   output logic                speed_search,
   output logic                inv_line_sel,
   output logic                comm_line_sel,
   output logic                run_cmd,
   output logic                reverse_cmd,
   output logic                fault_latched,
   output logic                output_enable,
   output logic                integrator_zero,
   output logic                alt_mode_sel,
   output logic                alt_gain_sel,
   output logic                current_ref_sel,
   output logic                excite_only,
   output logic [2:0]          program_sel,
   output logic                program_active,
   output logic [2:0]          program_step,
   output logic                second_func
);
   typedef struct packed {
      logic [2:0]   preset;
      logic [1:0]   ref_src;
      logic [2:0]   ramp;
      logic         up;
      logic         down;
      logic         hold;
      logic         brake;
      logic         search;
      dif_line_type line;
      logic [31:0]  gap;
      logic         run;
      logic         rev;
      logic         fault;
      logic         iclr;
      logic         alt_mode;
      logic         pgain;
      logic         iref;
      logic         excite;
      dif_seq_type  seq;
      logic [2:0]   prog;
      logic [2:0]   step;
      logic         go_prev;
      logic         second;
      logic         done;
   } dif_state_type;

   dif_state_type st_ff;
   dif_state_type nxt_st;
   logic [NIN-1:0] clean;
   dif_func_type   fn;

   // Code of terminal i, out-of-range codes read as unused
   function automatic logic [5:0] code_of(input logic [NIN*6-1:0] f,
                                          input int i);
      logic [5:0] c;
      c = f[i*6 +: 6];
      return c;
   endfunction : code_of

   // OR of all terminals whose code matches
   function automatic logic hit(input logic [NIN-1:0] v,
                                input logic [NIN*6-1:0] f,
                                input logic [5:0] code);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NIN; i++)
         if (code_of(f, i) == code && code <= `DIF_FN_MAX)
            r = r | v[i];
      return r;
   endfunction : hit

   dif_filter #(
      .W        (NIN),
      .UNIT_CYC (UNIT_CYC)
   ) u_filter (
      .clk          (clk),
      .arst_n       (arst_n),
      .pin_in       (term_pin),
      .filter_units (filter_units),
      .clean        (clean)
   );

   // Decode filtered terminals into function levels
   always_comb
   begin
      fn = '0;
      fn.speed = {hit(clean, term_func, `DIF_FN_SPEED_H),
                  hit(clean, term_func, `DIF_FN_SPEED_M),
                  hit(clean, term_func, `DIF_FN_SPEED_L)};
      fn.ramp = {hit(clean, term_func, `DIF_FN_RAMP_H),
                 hit(clean, term_func, `DIF_FN_RAMP_M),
                 hit(clean, term_func, `DIF_FN_RAMP_L)};
      fn.prog = {hit(clean, term_func, `DIF_FN_PROG_H),
                 hit(clean, term_func, `DIF_FN_PROG_M),
                 hit(clean, term_func, `DIF_FN_PROG_L)};
      fn.brake      = hit(clean, term_func, `DIF_FN_BRAKE);
      fn.second     = hit(clean, term_func, `DIF_FN_SECOND);
      fn.exchange   = hit(clean, term_func, `DIF_FN_EXCHANGE);
      fn.up         = hit(clean, term_func, `DIF_FN_UP);
      fn.down       = hit(clean, term_func, `DIF_FN_DOWN);
      fn.three_wire = hit(clean, term_func, `DIF_FN_THREE_WIRE);
      fn.trip_a     = hit(clean, term_func, `DIF_FN_TRIP_A);
      fn.trip_b     = hit(~clean, term_func, `DIF_FN_TRIP_B);
      fn.iclear     = hit(clean, term_func, `DIF_FN_ICLEAR);
      fn.open_loop  = hit(clean, term_func, `DIF_FN_OPEN_LOOP);
      fn.main_drive = hit(clean, term_func, `DIF_FN_MAIN_DRIVE);
      fn.ana_hold   = hit(clean, term_func, `DIF_FN_ANA_HOLD);
      fn.freeze     = hit(clean, term_func, `DIF_FN_FREEZE);
      fn.pgain2     = hit(clean, term_func, `DIF_FN_PGAIN2);
      fn.manual     = hit(clean, term_func, `DIF_FN_MANUAL);
      fn.go_step    = hit(clean, term_func, `DIF_FN_GO_STEP);
      fn.hold_step  = hit(clean, term_func, `DIF_FN_HOLD_STEP);
      fn.reset      = hit(clean, term_func, `DIF_FN_RESET);
      fn.halt       = hit(clean, term_func, `DIF_FN_HALT);
      fn.jog        = hit(clean, term_func, `DIF_FN_JOG);
      fn.fwd        = hit(clean, term_func, `DIF_FN_FWD);
      fn.rev        = hit(clean, term_func, `DIF_FN_REV);
      fn.ana_change = hit(clean, term_func, `DIF_FN_ANA_CHANGE);
      fn.pre_excite = hit(clean, term_func, `DIF_FN_PRE_EXCITE);
   end

   // Next state of the whole decoder
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.go_prev = fn.go_step;
      nxt_st.second  = fn.second;

      // Speed reference selection, jog wins over everything
      nxt_st.preset = fn.speed;
      if (fn.jog)
         nxt_st.ref_src = `DIF_REF_JOG;
      else if (fn.ana_hold && ref_is_analog)
         nxt_st.ref_src = `DIF_REF_HOLD;
      else if (fn.speed == 3'h0)
         nxt_st.ref_src = `DIF_REF_MODE;
      else
         nxt_st.ref_src = `DIF_REF_PRESET;

      nxt_st.ramp = fn.ramp;
      // Freeze beats up/down so speed stays put
      nxt_st.hold = fn.freeze;
      nxt_st.up   = fn.up && !fn.down && !fn.freeze;
      nxt_st.down = fn.down && !fn.up && !fn.freeze;

      // Braking refused while the motor turns
      nxt_st.brake = fn.brake && motor_stopped;

      nxt_st.iclr   = fn.iclear;
      nxt_st.pgain  = fn.pgain2;
      nxt_st.iref   = fn.ana_change;

      // Mode change sampled only at standstill
      if (motor_stopped)
         nxt_st.alt_mode = fn.open_loop | fn.main_drive | fn.manual;

      // Trips latch until reset terminal; set wins over reset
      if (fn.trip_a || fn.trip_b)
         nxt_st.fault = 1'b1;
      else if (fn.reset)
         nxt_st.fault = 1'b0;

      // Run command, latched from push buttons in three-wire mode
      if (nxt_st.fault || fn.halt)
         nxt_st.run = 1'b0;
      else if (fn.three_wire)
      begin
         if (fn.fwd || fn.rev)
            nxt_st.run = 1'b1;
         nxt_st.hold = st_ff.run ? 1'b1 : fn.freeze;
         if (!st_ff.run)
            nxt_st.hold = fn.freeze;
      end
      else
         nxt_st.run = fn.fwd | fn.rev;
      if (fn.fwd || fn.rev)
         nxt_st.rev = fn.rev && !fn.fwd;

      // Finished program waits for run release, else a held level restarts
      if (!(fn.fwd || fn.rev))
         nxt_st.done = 1'b0;
      if (st_ff.done && auto_mode)
         nxt_st.run = 1'b0;

      // Pre-excitation ends once running
      nxt_st.excite = fn.pre_excite && !nxt_st.run;

      // Line changeover with interlock gap both ways
      case (st_ff.line)
         DIF_LINE_INV:
         begin
            if (fn.exchange)
            begin
               nxt_st.line = DIF_GAP_COMM;
               nxt_st.gap  = 32'h0;
            end
         end
         DIF_GAP_COMM:
         begin
            if (st_ff.gap >= 32'(GAP_CYC - 1))
               nxt_st.line = DIF_LINE_COMM;
            else
               nxt_st.gap = st_ff.gap + 32'h1;
         end
         DIF_LINE_COMM:
         begin
            if (!fn.exchange)
            begin
               nxt_st.line = DIF_GAP_INV;
               nxt_st.gap  = 32'h0;
            end
         end
         DIF_GAP_INV:
         begin
            if (st_ff.gap >= 32'(GAP_CYC - 1))
               nxt_st.line = DIF_LINE_INV;
            else
               nxt_st.gap = st_ff.gap + 32'h1;
         end
         default:
            nxt_st.line = DIF_LINE_INV;
      endcase
      nxt_st.search = (nxt_st.line != DIF_LINE_INV) || fn.exchange;

      // Sequence program: choose, step, finish or halt
      case (st_ff.seq)
         DIF_SEQ_IDLE:
         begin
            if (auto_mode && nxt_st.run && !fn.halt &&
                (fn.prog == 3'h1 || fn.prog == 3'h2 || fn.prog == 3'h4 ||
                 fn.prog == 3'h3 || fn.prog == 3'h5))
            begin
               nxt_st.seq  = DIF_SEQ_RUN;
               nxt_st.prog = fn.prog;
               nxt_st.step = `DIF_STEP_FIRST;
            end
         end
         DIF_SEQ_RUN:
         begin
            if (fn.halt)
               nxt_st.seq = DIF_SEQ_IDLE;
            else if ((auto_stepped && fn.go_step && !st_ff.go_prev) ||
                     (!auto_stepped && step_done))
            begin
               if (st_ff.step == `DIF_STEPS)
               begin
                  if (!auto_stepped && fn.hold_step)
                     nxt_st.seq = DIF_SEQ_HOLD;
                  else
                     nxt_st.seq = DIF_SEQ_IDLE;
               end
               else
                  nxt_st.step = st_ff.step + 3'h1;
            end
         end
         DIF_SEQ_HOLD:
         begin
            // Last step frequency kept while hold input stays on and halt is off
            if (fn.halt || !fn.hold_step)
               nxt_st.seq = DIF_SEQ_IDLE;
         end
         default:
            nxt_st.seq = DIF_SEQ_IDLE;
      endcase
      if (st_ff.seq != DIF_SEQ_IDLE && nxt_st.seq == DIF_SEQ_IDLE &&
          auto_mode)
      begin
         nxt_st.run  = 1'b0;
         nxt_st.done = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff      <= '0;
         st_ff.line <= DIF_LINE_INV;
         st_ff.seq  <= DIF_SEQ_IDLE;
         // Select bits read all off, so the mode source is in use
         st_ff.ref_src <= `DIF_REF_MODE;
      end
      else
         st_ff <= nxt_st;
   end

   // Outputs from state flops; line selects, output_enable and program_active decoded from them
   assign preset_index    = st_ff.preset;
   assign ref_source      = st_ff.ref_src;
   assign ramp_index      = st_ff.ramp;
   assign ramp_up         = st_ff.up;
   assign ramp_down       = st_ff.down;
   assign ramp_hold       = st_ff.hold;
   assign brake_on        = st_ff.brake;
   assign speed_search    = st_ff.search;
   assign inv_line_sel    = (st_ff.line == DIF_LINE_INV);
   assign comm_line_sel   = (st_ff.line == DIF_LINE_COMM);
   assign run_cmd         = st_ff.run;
   assign reverse_cmd     = st_ff.rev;
   assign fault_latched   = st_ff.fault;
   assign output_enable   = !st_ff.fault;
   assign integrator_zero = st_ff.iclr;
   assign alt_mode_sel    = st_ff.alt_mode;
   assign alt_gain_sel    = st_ff.pgain;
   assign current_ref_sel = st_ff.iref;
   assign excite_only     = st_ff.excite;
   assign program_sel     = st_ff.prog;
   assign program_active  = (st_ff.seq != DIF_SEQ_IDLE);
   assign program_step    = st_ff.step;
   assign second_func     = st_ff.second;
endmodule : dif_decoder
`default_nettype wire

// file: verif/dif_switches.sv
// Terminal switch and push-button model for the decoder inputs
`timescale 1ns/1ps
`default_nettype none
module dif_switches
(
   input  wire logic       clk,
   input  wire logic [7:0] want,
   output logic [7:0]      term_pin
);
   // Contacts move only on the rising edge, as a relay would settle
   always_ff @(posedge clk)
   begin
      term_pin <= want;
   end
endmodule : dif_switches
`default_nettype wire

// file: verif/dif_decoder_asserts.sv
// Port checker for the terminal decoder
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_decoder_chk
#(
   parameter int GAP_CYC = 8
)
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       motor_stopped,
   input  wire logic       ref_is_analog,
   input  wire logic [2:0] preset_index,
   input  wire logic [1:0] ref_source,
   input  wire logic       brake_on,
   input  wire logic       speed_search,
   input  wire logic       inv_line_sel,
   input  wire logic       comm_line_sel,
   input  wire logic       fault_latched,
   input  wire logic       output_enable,
   input  wire logic       alt_mode_sel,
   input  wire logic       program_active,
   input  wire logic [2:0] program_step
);
   logic [15:0] gap_ff;
   logic [15:0] nxt_gap;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Cycles with both line selects off; saturates so it never wraps
   always_comb
   begin
      nxt_gap = gap_ff + {15'h0000, ~&gap_ff};
      if (inv_line_sel || comm_line_sel)
         nxt_gap = 16'h0000;
   end
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         gap_ff <= 16'h0000;
      else
         gap_ff <= nxt_gap;
   end
   property p_oe;
      output_enable == !fault_latched;
   endproperty
   a_oe: assert property (p_oe)
      else $error("output enable disagrees with fault");
   property p_brake;
      brake_on |-> $past(motor_stopped);
   endproperty
   a_brake: assert property (p_brake)
      else $error("braking while motor running");
   property p_gap;
      $rose(inv_line_sel) || $rose(comm_line_sel) |-> gap_ff >= GAP_CYC;
   endproperty
   a_gap: assert property (p_gap)
      else $error("line select interlock gap too short");
   property p_excl;
      !(inv_line_sel && comm_line_sel);
   endproperty
   a_excl: assert property (p_excl)
      else $error("both line selects on");
   property p_search;
      $fell(inv_line_sel) |-> speed_search;
   endproperty
   a_search: assert property (p_search)
      else $error("no speed search at changeover");
   property p_ref;
      ref_source inside {`DIF_REF_PRESET, `DIF_REF_MODE} |->
         ((ref_source == `DIF_REF_MODE) == (preset_index == 3'h0));
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference source disagrees with preset index");
   property p_hold;
      ref_source == `DIF_REF_HOLD |-> $past(ref_is_analog);
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold without analog reference");
   property p_mode;
      $changed(alt_mode_sel) |-> $past(motor_stopped);
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode changed while running");
   property p_step;
      program_active && $past(program_active) && $changed(program_step)
         |-> program_step == $past(program_step) + 3'h1;
   endproperty
   a_step: assert property (p_step)
      else $error("sequence step skipped");
   c_brake: cover property (brake_on);
   c_comm: cover property ($rose(comm_line_sel));
   c_fault: cover property (fault_latched);
   c_step: cover property (program_active && program_step == 3'h2);
endmodule : dif_decoder_chk
bind dif_decoder dif_decoder_chk #(.GAP_CYC(GAP_CYC)) u_chk (.clk, .arst_n,
   .motor_stopped, .ref_is_analog, .preset_index, .ref_source, .brake_on,
   .speed_search, .inv_line_sel, .comm_line_sel, .fault_latched,
   .output_enable, .alt_mode_sel, .program_active, .program_step);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the terminal decoder
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module testbench;
   localparam int GAP = 8;
   logic clk = 1'b0, arst_n = 1'b0, motor_stopped = 1'b1, auto_mode = 1'b0;
   logic auto_stepped = 1'b1, ref_is_analog = 1'b0, step_done = 1'b0;
   logic [7:0] want = 8'h00, term_pin, filter_units = 8'h00;
   logic [47:0] term_func = '0;
   logic [2:0] preset_index, ramp_index, program_sel, program_step, c;
   logic [1:0] ref_source;
   logic ramp_up, ramp_down, ramp_hold, brake_on, speed_search, inv_line_sel;
   logic comm_line_sel, run_cmd, reverse_cmd, fault_latched, output_enable;
   logic integrator_zero, alt_mode_sel, alt_gain_sel, current_ref_sel, j;
   logic excite_only, program_active, second_func;
   logic [7:0] lvl_vec;
   logic [5:0] lvl_tab [8] = '{`DIF_FN_ICLEAR, `DIF_FN_PGAIN2,
      `DIF_FN_ANA_CHANGE, `DIF_FN_PRE_EXCITE, `DIF_FN_ANA_HOLD,
      `DIF_FN_FREEZE, `DIF_FN_UP, `DIF_FN_DOWN};
   int num_errors = 0, cmp_count = 0, seed, r;
   assign lvl_vec = {ramp_down, ramp_up, ramp_hold,
      ref_source == `DIF_REF_HOLD, excite_only, current_ref_sel, alt_gain_sel,
      integrator_zero};
   always #10 clk = ~clk;
   dif_switches SW (.clk, .want, .term_pin);
   dif_decoder #(.NIN(8), .UNIT_CYC(4), .GAP_CYC(GAP)) DUT (.clk, .arst_n,
      .term_pin, .term_func, .filter_units, .motor_stopped, .auto_mode,
      .auto_stepped, .ref_is_analog, .step_done, .preset_index, .ref_source,
      .ramp_index, .ramp_up, .ramp_down, .ramp_hold, .brake_on, .speed_search,
      .inv_line_sel, .comm_line_sel, .run_cmd, .reverse_cmd, .fault_latched,
      .output_enable, .integrator_zero, .alt_mode_sel, .alt_gain_sel,
      .current_ref_sel, .excite_only, .program_sel, .program_active,
      .program_step, .second_func);
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
         begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Covers sync, filter and output register with margin
   task automatic settle();
      repeat (10) @(negedge clk);
   endtask : settle
   task automatic map(input int i, input logic [5:0] code);
      term_func[i*6+:6] = code;
   endtask : map
   function automatic logic [1:0] exp_src(input logic [2:0] s, input logic k);
      if (k)
         return `DIF_REF_JOG;
      return (s == 3'h0) ? `DIF_REF_MODE : `DIF_REF_PRESET;
   endfunction : exp_src
   // Bounded walk of one changeover; counts the gap between the selects
   task automatic walk(input logic to_comm);
      int n;
      n = 0;
      while ((to_comm ? inv_line_sel : comm_line_sel) !== 1'b0 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 40)
      begin
         num_errors++;
         conclude();
      end
      if (to_comm)
         chk(8'(speed_search), 8'h01);
      n = 0;
      while ((to_comm ? comm_line_sel : inv_line_sel) !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 40)
      begin
         num_errors++;
         conclude();
      end
      chk(8'(n), 8'(GAP));
   endtask : walk
   initial
   begin
      seed = 32'h45e0;
      map(0, `DIF_FN_SPEED_L);
      map(1, `DIF_FN_SPEED_M);
      map(2, `DIF_FN_SPEED_H);
      map(3, `DIF_FN_JOG);
      map(4, `DIF_FN_BRAKE);
      map(5, `DIF_FN_TRIP_A);
      map(6, `DIF_FN_RESET);
      map(7, `DIF_FN_EXCHANGE);
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      chk(8'({inv_line_sel, output_enable}), 8'h03);
      // Debounce: held level needs the filter time, a short dip is ignored
      filter_units = 8'h02;
      want[3] = 1'b1;
      repeat (8) @(negedge clk);
      chk(8'(ref_source), 8'(`DIF_REF_MODE));
      settle();
      chk(8'(ref_source), 8'(`DIF_REF_JOG));
      want[3] = 1'b0;
      repeat (3) @(negedge clk);
      want[3] = 1'b1;
      repeat (3) @(negedge clk);
      chk(8'(ref_source), 8'(`DIF_REF_JOG));
      want[3] = 1'b0;
      repeat (20) @(negedge clk);
      filter_units = 8'h00;
      // Every speed word, then random words with jog mixed in
      for (int i = 0; i < 24; i++)
      begin
         r = $random(seed);
         c = (i < 8) ? 3'(i) : r[2:0];
         j = (i >= 8) && r[3];
         want[3:0] = {j, c};
         settle();
         chk(8'(ref_source), 8'(exp_src(c, j)));
         if (!j)
            chk(8'(preset_index), 8'(c));
      end
      want = 8'h00;
      for (int i = 0; i < 3; i++)
         map(i, 6'(`DIF_FN_RAMP_L + i));
      for (int i = 0; i < 8; i++)
      begin
         want[2:0] = 3'(7 - i);
         settle();
         chk(8'(ramp_index), 8'(7 - i));
      end
      // Brake request refused while running
      motor_stopped = 1'b0;
      want[4] = 1'b1;
      settle();
      chk(8'(brake_on), 8'h00);
      motor_stopped = 1'b1;
      settle();
      chk(8'(brake_on), 8'h01);
      want[4] = 1'b0;
      want[5] = 1'b1;
      settle();
      want[5] = 1'b0;
      settle();
      chk(8'({fault_latched, output_enable}), 8'h02);
      want[6] = 1'b1;
      settle();
      chk(8'({fault_latched, output_enable}), 8'h01);
      map(5, `DIF_FN_TRIP_B);
      want[5] = 1'b1;
      settle();
      want[6] = 1'b0;
      settle();
      chk(8'({fault_latched, output_enable}), 8'h01);
      want[5] = 1'b0;
      settle();
      chk(8'({fault_latched, output_enable}), 8'h02);
      map(5, 6'h09);
      want[6] = 1'b1;
      settle();
      want[6] = 1'b0;
      chk(8'(fault_latched), 8'h00);
      want[7] = 1'b1;
      walk(1'b1);
      settle();
      want[7] = 1'b0;
      walk(1'b0);
      ref_is_analog = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         map(4, lvl_tab[i]);
         want[4] = 1'b1;
         settle();
         chk(lvl_vec, 8'h01 << i);
         want[4] = 1'b0;
         settle();
         chk(8'(lvl_vec), 8'h00);
      end
      // Mode change refused while running
      map(4, `DIF_FN_OPEN_LOOP);
      motor_stopped = 1'b0;
      want[4] = 1'b1;
      settle();
      chk(8'(alt_mode_sel), 8'h00);
      motor_stopped = 1'b1;
      settle();
      chk(8'(alt_mode_sel), 8'h01);
      want[4] = 1'b0;
      for (int i = 0; i < 3; i++)
         map(i, 6'(`DIF_FN_PROG_L + i));
      map(3, `DIF_FN_FWD);
      map(4, `DIF_FN_GO_STEP);
      map(6, `DIF_FN_HALT);
      auto_mode = 1'b1;
      want = 8'h0b;
      settle();
      chk(8'({program_active, program_sel}), 8'h0b);
      repeat (2)
      begin
         want[4] = 1'b1;
         settle();
         want[4] = 1'b0;
         settle();
      end
      chk(8'(program_step), 8'h02);
      want[6] = 1'b1;
      settle();
      chk(8'(program_active), 8'h00);
      // Free-running program: timed steps, hold-step keeps the last one
      map(7, `DIF_FN_HOLD_STEP);
      auto_stepped = 1'b0;
      want = 8'h83;
      settle();
      want[3] = 1'b1;
      settle();
      repeat (8)
      begin
         step_done = 1'b1;
         @(negedge clk);
         step_done = 1'b0;
         @(negedge clk);
      end
      chk(8'({program_active, run_cmd, program_step}), 8'h1f);
      want[7] = 1'b0;
      settle();
      chk(8'({program_active, run_cmd}), 8'h00);
      // Three-wire: a press latches run, the halt button drops it
      auto_mode = 1'b0;
      map(4, `DIF_FN_REV);
      map(7, `DIF_FN_THREE_WIRE);
      want = 8'h90;
      settle();
      chk(8'({run_cmd, reverse_cmd, ramp_hold}), 8'h07);
      want[4] = 1'b0;
      settle();
      chk(8'({run_cmd, reverse_cmd, ramp_hold}), 8'h07);
      want[6] = 1'b1;
      settle();
      chk(8'({run_cmd, ramp_hold}), 8'h00);
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(8'({inv_line_sel, output_enable, fault_latched}), 8'h06);
      arst_n = 1'b1;
      want = 8'h00;
      settle();
      conclude();
   end
endmodule : testbench
`default_nettype wire
